// *** verilog/rsc_pkg.sv ***
// Purpose: shared constants and state type for the reset source combiner
// Assumes: 16-bit register data, one clock at 50 MHz
// Notes:   bit positions of the reset cause/status register live here
package rsc_pkg;

   // register port
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 16;
   localparam logic [3:0]  OFS_STATUS      = 4'h0;
   localparam logic [3:0]  OFS_LIVE        = 4'h1;

   // reset cause/status register fields
   localparam int          B_TRAP          = 15;
   localparam int          B_ILLEGAL       = 14;
   localparam int          B_FLASH_REG     = 11;
   localparam int          B_CFG_MISMATCH  = 9;
   localparam int          B_MAIN_REG      = 8;
   localparam int          B_EXT_PIN       = 7;
   localparam int          B_SW_RESET      = 6;
   localparam int          B_SOFT_WDT_EN   = 5;
   localparam int          B_WDT_TIMEOUT   = 4;
   localparam int          B_SLEEP         = 3;
   localparam int          B_IDLE          = 2;
   localparam int          B_BROWN_OUT     = 1;
   localparam int          B_POWER_ON      = 0;
   localparam logic [15:0] STATUS_MASK     = 16'hCBFF;
   localparam logic [15:0] STATUS_POR_VAL  = 16'h0003;

   // live status register fields
   localparam int          L_SYS_RESET     = 0;
   localparam int          L_BROWN_OUT     = 1;
   localparam int          L_EXT_PIN       = 2;
   localparam int          L_WDT_EN        = 3;

   // configuration
   localparam int          CLKSEL_W        = 3;
   localparam logic [1:0]  WDT_CFG_ALWAYS  = 2'h3;

   // reset sources fed to the stretcher
   localparam int          NUM_SRC         = 10;

   // timing
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          RST_HOLD_NS     = 100;
   localparam int          RST_HOLD_CYC    =
      (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          HOLD_CNT_W      = 4;

   typedef struct packed {
      logic [DATA_W-1:0]   status;
      logic [DATA_W-1:0]   rdata;
      logic [CLKSEL_W-1:0] clksel;
   } rsc_core_s;

endpackage : rsc_pkg

// *** verilog/rsc_sync.sv ***
// Purpose: two-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, not pulses
// Notes:   stage one is read only by stage two
`timescale 1ns/1ps
module rsc_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } rsc_sync_s;

   rsc_sync_s st_r;
   rsc_sync_s st_nxt;

   always_comb begin
      st_nxt        = st_r;
      st_nxt.stage1 = async_in;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '{stage1: RESET_VAL, stage2: RESET_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sync_out = st_r.stage2;

endmodule : rsc_sync

// *** verilog/rsc_reset_stretch.sv ***
// Purpose: ORs reset sources and holds the system reset a while after
// Assumes: all source inputs are on clk
// Notes:   release is a registered edge on clk
`timescale 1ns/1ps
module rsc_reset_stretch #(
   parameter int NUM_SRC  = rsc_pkg::NUM_SRC,
   parameter int HOLD_CYC = rsc_pkg::RST_HOLD_CYC,
   parameter int CNT_W    = rsc_pkg::HOLD_CNT_W
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [NUM_SRC-1:0] src_active,
   output logic                    sys_reset
);

   localparam logic [CNT_W-1:0] HOLD_VAL = CNT_W'(HOLD_CYC);

   typedef struct packed {
      logic             active;
      logic [CNT_W-1:0] cnt;
   } rsc_stretch_s;

   rsc_stretch_s st_r;
   rsc_stretch_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (|src_active) begin
         // any source asserts and re-arms the hold
         st_nxt.active = 1'b1;
         st_nxt.cnt    = HOLD_VAL;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt    = st_r.cnt - CNT_W'(1);
      end else begin
         st_nxt.active = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= '{active: 1'b1, cnt: HOLD_VAL};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign sys_reset = st_r.active;

endmodule : rsc_reset_stretch

// *** verilog/rsc_reset_combiner.sv ***
// Purpose: reset source combiner with reset cause/status register
// Assumes: rst_n is the power-on reset; cpu events are clk pulses
// Notes:   configuration inputs are static fuse values
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps

module rsc_reset_combiner #(
   parameter int HOLD_CYC = rsc_pkg::RST_HOLD_CYC
) (
   input  wire logic                         clk,
   input  wire logic                         rst_n,
   // reset sources
   input  wire logic                         brown_out_reset,
   input  wire logic                         external_clear_pin_n,
   input  wire logic                         sw_reset_req,
   input  wire logic                         watchdog_timeout,
   input  wire logic                         config_mismatch,
   input  wire logic                         trap_conflict,
   input  wire logic                         illegal_opcode,
   input  wire logic                         uninit_wreg_ptr,
   input  wire logic                         security_violation,
   input  wire logic                         illegal_addr_mode,
   // power-saving events
   input  wire logic                         sleep_entered,
   input  wire logic                         idle_entered,
   // configuration word fields
   input  wire logic [rsc_pkg::CLKSEL_W-1:0] initial_clock_source_cfg,
   input  wire logic [1:0]                   watchdog_enable_cfg,
   // register port
   input  wire logic [rsc_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [rsc_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [rsc_pkg::DATA_W-1:0]   reg_rdata,
   // outputs
   output logic                              master_system_reset,
   output logic      [rsc_pkg::CLKSEL_W-1:0] clock_source_sel,
   output logic                              watchdog_enable,
   output logic                              flash_regulator_sleep_active,
   output logic                              main_regulator_sleep_active
);

   rsc_pkg::rsc_core_s             st_r;
   rsc_pkg::rsc_core_s             st_nxt;

   logic [1:0]                     pins_s;
   logic                           brown_out_s;
   logic                           ext_pin_active;
   logic                           illegal_any;
   logic [rsc_pkg::NUM_SRC-1:0]    src_vec;
   logic                           sys_reset;
   logic                           wdt_en;
   logic                           status_wr;
   logic [rsc_pkg::DATA_W-1:0]     set_vec;
   logic [rsc_pkg::DATA_W-1:0]     live_vec;
   logic [rsc_pkg::DATA_W-1:0]     base_vec;

   // pin inputs cross into clk; clear pin idles high
   rsc_sync #(
      .WIDTH     (2),
      .RESET_VAL (2'h2)
   ) u_pin_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({external_clear_pin_n, brown_out_reset}),
      .sync_out (pins_s)
   );

   assign brown_out_s    = pins_s[0];
   assign ext_pin_active = ~pins_s[1];

   // four illegal conditions share one flag
   assign illegal_any = illegal_opcode | uninit_wreg_ptr |
                        security_violation | illegal_addr_mode;

   // every source that forces the master reset
   assign src_vec = {brown_out_s,
                     ext_pin_active,
                     sw_reset_req,
                     watchdog_timeout,
                     config_mismatch,
                     trap_conflict,
                     illegal_opcode,
                     uninit_wreg_ptr,
                     security_violation,
                     illegal_addr_mode};

   // power-on reset enters through rst_n
   rsc_reset_stretch #(
      .NUM_SRC  (rsc_pkg::NUM_SRC),
      .HOLD_CYC (HOLD_CYC),
      .CNT_W    (rsc_pkg::HOLD_CNT_W)
   ) u_stretch (
      .clk        (clk),
      .rst_n      (rst_n),
      .src_active (src_vec),
      .sys_reset  (sys_reset)
   );

   // config value 11 overrides the soft enable
   assign wdt_en = st_r.status[rsc_pkg::B_SOFT_WDT_EN] |
                   (watchdog_enable_cfg == rsc_pkg::WDT_CFG_ALWAYS);

   assign status_wr = reg_wr && (reg_addr == rsc_pkg::OFS_STATUS);

   // hardware set terms, one per cause
   always_comb begin
      set_vec                             = '0;
      set_vec[rsc_pkg::B_TRAP]            = trap_conflict;
      set_vec[rsc_pkg::B_ILLEGAL]         = illegal_any;
      set_vec[rsc_pkg::B_CFG_MISMATCH]    = config_mismatch;
      set_vec[rsc_pkg::B_EXT_PIN]         = ext_pin_active;
      set_vec[rsc_pkg::B_SW_RESET]        = sw_reset_req;
      set_vec[rsc_pkg::B_WDT_TIMEOUT]     = watchdog_timeout;
      set_vec[rsc_pkg::B_SLEEP]           = sleep_entered;
      set_vec[rsc_pkg::B_IDLE]            = idle_entered;
      set_vec[rsc_pkg::B_BROWN_OUT]       = brown_out_s;
   end

   // live view of the block, read only
   always_comb begin
      live_vec                         = '0;
      live_vec[rsc_pkg::L_SYS_RESET]   = sys_reset;
      live_vec[rsc_pkg::L_BROWN_OUT]   = brown_out_s;
      live_vec[rsc_pkg::L_EXT_PIN]     = ext_pin_active;
      live_vec[rsc_pkg::L_WDT_EN]      = wdt_en;
   end

   always_comb begin
      st_nxt   = st_r;
      base_vec = st_r.status;

      // software writes any flag; no write path reaches the reset
      if (status_wr) begin
         base_vec = reg_wdata;
      end

      // a cause arriving with a clear still sets its flag
      st_nxt.status = (base_vec | set_vec) & rsc_pkg::STATUS_MASK;

      // read data stands for one cycle only
      st_nxt.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            rsc_pkg::OFS_STATUS: begin
               st_nxt.rdata = st_r.status & rsc_pkg::STATUS_MASK;
            end
            rsc_pkg::OFS_LIVE: begin
               st_nxt.rdata = live_vec;
            end
            default: begin
               st_nxt.rdata = '0;
            end
         endcase
      end

      // clock source reloaded during any reset
      if (sys_reset) begin
         st_nxt.clksel = initial_clock_source_cfg;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         // power-on value: only power-on and brown-out set
         st_r.status <= rsc_pkg::STATUS_POR_VAL;
         st_r.rdata  <= '0;
         st_r.clksel <= initial_clock_source_cfg;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata                    = st_r.rdata;
   assign master_system_reset          = sys_reset;
   assign clock_source_sel             = st_r.clksel;
   assign watchdog_enable              = wdt_en;
   assign flash_regulator_sleep_active = st_r.status[rsc_pkg::B_FLASH_REG];
   assign main_regulator_sleep_active  = st_r.status[rsc_pkg::B_MAIN_REG];

endmodule : rsc_reset_combiner

// *** verif/rsc_reset_combiner_assertions.sv ***
// Purpose: port-level checks on the reset source combiner
// Assumes: HOLD_CYC of 5 or more, configuration static during reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ps
module rsc_checker #(
   parameter int HOLD_CYC = 5
) (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        brown_out_reset,
   input wire logic        external_clear_pin_n,
   input wire logic        sw_reset_req,
   input wire logic        watchdog_timeout,
   input wire logic        config_mismatch,
   input wire logic        trap_conflict,
   input wire logic        illegal_opcode,
   input wire logic        uninit_wreg_ptr,
   input wire logic        security_violation,
   input wire logic        illegal_addr_mode,
   input wire logic [2:0]  initial_clock_source_cfg,
   input wire logic [1:0]  watchdog_enable_cfg,
   input wire logic [3:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic        master_system_reset,
   input wire logic [2:0]  clock_source_sel,
   input wire logic        watchdog_enable,
   input wire logic        flash_regulator_sleep_active,
   input wire logic        main_regulator_sleep_active
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire src_any = trap_conflict | illegal_opcode | uninit_wreg_ptr
      | security_violation | illegal_addr_mode | config_mismatch
      | sw_reset_req | watchdog_timeout;
   // pins and supervisor quiet as well
   wire quiet = !src_any && external_clear_pin_n && !brown_out_reset;
   property p_src_rst; src_any |=> master_system_reset; endproperty
   a_src_rst: assert property (p_src_rst) else $error("no reset");
   property p_stretch; $fell(src_any) |-> master_system_reset[*5]; endproperty
   a_stretch: assert property (p_stretch) else $error("early");
   property p_por; $rose(rst_n) |-> master_system_reset[*5]; endproperty
   a_por: assert property (p_por) else $error("por hold");
   property p_rsvd; reg_rd && reg_addr == rsc_pkg::OFS_STATUS |=>
      reg_rdata[13:12] == 2'h0 && !reg_rdata[10]; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   property p_wr_quiet; quiet[*3] ##0 (reg_wr && !master_system_reset)
      |=> !master_system_reset; endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("wr rst");
   property p_clksel; master_system_reset |=>
      clock_source_sel == $past(initial_clock_source_cfg); endproperty
   a_clksel: assert property (p_clksel) else $error("clksel");
   property p_wdt_cfg; watchdog_enable_cfg == 2'h3 |-> watchdog_enable;
   endproperty
   a_wdt_cfg: assert property (p_wdt_cfg) else $error("wdt");
   property p_regs; reg_wr && reg_addr == rsc_pkg::OFS_STATUS |=>
      flash_regulator_sleep_active == $past(reg_wdata[11]) &&
      main_regulator_sleep_active == $past(reg_wdata[8]); endproperty
   a_regs: assert property (p_regs) else $error("vreg");
endmodule : rsc_checker

bind rsc_reset_combiner rsc_checker #(.HOLD_CYC(HOLD_CYC)) u_chk (
   .clk, .rst_n, .brown_out_reset, .external_clear_pin_n, .sw_reset_req,
   .watchdog_timeout, .config_mismatch, .trap_conflict, .illegal_opcode,
   .uninit_wreg_ptr, .security_violation, .illegal_addr_mode,
   .initial_clock_source_cfg, .watchdog_enable_cfg, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .master_system_reset, .clock_source_sel,
   .watchdog_enable, .flash_regulator_sleep_active,
   .main_regulator_sleep_active);

// *** verif/rsc_src_model.sv ***
// Purpose: reset sources and cpu events seen by the combiner
// Assumes: one request pulse per event
// Notes:   each event is a three-cycle active-high level
`timescale 1ns/1ps
module rsc_src_model (
   input  wire logic        clk,
   input  wire logic [11:0] fire,
   output logic      [11:0] src
);
   logic [11:0] s1 = '0;
   logic [11:0] s2 = '0;
   logic [11:0] s3 = '0;
   always @(posedge clk) begin
      s1 <= fire;
      s2 <= s1;
      s3 <= s2;
   end
   assign src = s1 | s2 | s3;
endmodule : rsc_src_model

// *** verif/testbench.sv ***
// Purpose: self-checking bench for the reset source combiner
// Assumes: HOLD_CYC of 5, status model kept in exp
// Notes:   sources come from the partner model
`timescale 1ns/1ps
module testbench;
   logic        clk = 0;
   logic        rst_n = 0;
   logic [11:0] fire = '0;
   logic [11:0] src;
   logic [2:0]  cfg = '0;
   logic [1:0]  wcfg = '0;
   logic [3:0]  reg_addr = '0;
   logic [15:0] reg_wdata = '0;
   logic        reg_wr = 0;
   logic        reg_rd = 0;
   logic [15:0] reg_rdata, d;
   logic        msr, wdt_en, flash_on, main_on;
   integer      hi_n = 0, n0 = 0;
   logic [2:0]  clk_sel;
   integer      fail_count = 0, checks = 0, seed = 32'hef76, exp, i;
   int          bt [12] = '{15, 14, 14, 14, 14, 9, 7, 6, 4, 1, 3, 2};
   initial forever #10 clk = ~clk;
   // counts cycles with the master reset high, single driver
   always @(posedge clk) if (msr) hi_n <= hi_n + 1;
   rsc_src_model PM (.clk, .fire, .src);
   rsc_reset_combiner #(.HOLD_CYC(5)) DUT (
      .clk, .rst_n, .brown_out_reset(src[9]),
      .external_clear_pin_n(~src[6]), .sw_reset_req(src[7]),
      .watchdog_timeout(src[8]), .config_mismatch(src[5]),
      .trap_conflict(src[0]), .illegal_opcode(src[1]),
      .uninit_wreg_ptr(src[2]), .security_violation(src[3]),
      .illegal_addr_mode(src[4]), .sleep_entered(src[10]),
      .idle_entered(src[11]), .initial_clock_source_cfg(cfg),
      .watchdog_enable_cfg(wcfg), .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .master_system_reset(msr),
      .clock_source_sel(clk_sel), .watchdog_enable(wdt_en),
      .flash_regulator_sleep_active(flash_on),
      .main_regulator_sleep_active(main_on));
   task chk(input logic [15:0] seen, input logic [15:0] expv);
      checks++;
      if (seen !== expv) begin
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
         fail_count++;
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [15:0] dv);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= dv;
      reg_wr <= 1;
      if (a == 4'h0) exp = dv & 16'hCBFF;
      @(posedge clk);
      reg_wr <= 0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge clk);
      reg_rd <= 0;
      #1 chk(reg_rdata, e);
   endtask : rd
   task settle;
      int n;
      n = 0;
      repeat (6) @(posedge clk);
      while (msr !== 1'b0 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n == 40) chk(1, 0);
   endtask : settle
   task por;
      rst_n <= 0;
      repeat (16) @(posedge clk);
      rst_n <= 1;
      exp = 16'h0003;
      settle;
   endtask : por
   task give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   initial begin
      #400000;
      fail_count++;
      give_verdict;
   end
   initial begin
      por;
      rd(4'h0, exp);
      n0 = hi_n;
      wr(4'h0, 16'hFFFF);
      rd(4'h0, exp);
      chk({flash_on, main_on}, 16'h3);
      chk(16'(hi_n - n0), 16'h0);
      wr(4'h1, 16'hFFFF);
      rd(4'h0, exp);
      rd(4'h7, 16'h0000);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         wcfg <= i[1:0];
         d = 16'($random(seed));
         wr(4'h0, d);
         rd(4'h0, exp);
         chk(wdt_en, d[5] | (i == 3));
         rd(4'h1, {12'h0, d[5] | (i == 3), 3'h0});
      end
      for (i = 0; i < 12; i++) begin
         wr(4'h0, 16'h0000);
         if (i < 10) cfg <= 3'($random(seed));
         n0 = hi_n;
         @(posedge clk);
         fire <= 12'h1 << i;
         @(posedge clk);
         fire <= '0;
         settle;
         exp = exp | (1 << bt[i]);
         // three-cycle source plus a hold of five cycles
         chk(16'(hi_n - n0), (i < 10) ? 16'h8 : 16'h0);
         chk(clk_sel, cfg);
         rd(4'h0, exp);
      end
      wr(4'h0, 16'hFFFF);
      por;
      rd(4'h0, 16'h0003);
      give_verdict;
   end
endmodule : testbench
